//--- vac_pkg.sv
// vac_pkg: constants shared by the attribute controller files
package vac_pkg;

    // ****************************************************************
    // host i/o ports
    // ****************************************************************
    localparam logic [15:0] INDEX_PORT_ADDR = 16'h03C0;
    localparam logic [15:0] DATA_PORT_ADDR = 16'h03C1;

    // ****************************************************************
    // register indices
    // ****************************************************************
    localparam logic [4:0] IDX_PALETTE_LAST = 5'h0F;
    localparam logic [4:0] IDX_MODE_CONTROL = 5'h10;
    localparam logic [4:0] IDX_BORDER_COLOUR = 5'h11;
    localparam logic [4:0] IDX_PLANE_ENABLE = 5'h12;
    localparam logic [4:0] IDX_HORIZ_PAN = 5'h13;
    localparam logic [4:0] IDX_PIXEL_PAD = 5'h14;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int PAL_SRC_BIT = 5;
    localparam int MODE_PAD54_BIT = 7;
    localparam int MODE_256_BIT = 6;
    localparam int MODE_PANFORCE_BIT = 5;
    localparam int MODE_RSVD_BIT = 4;
    localparam int MODE_BLINK_BIT = 3;
    localparam int MODE_LINEGFX_BIT = 2;
    localparam int MODE_MONO_BIT = 1;
    localparam int MODE_GRAPHICS_BIT = 0;

    // ****************************************************************
    // reset values and masks
    // ****************************************************************
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] BORDER_RESET = 8'h00;
    localparam logic [7:0] PLANE_EN_RESET = 8'h00;
    localparam logic [7:0] PAN_RESET = 8'h00;
    localparam logic [7:0] PAD_RESET = 8'h00;
    localparam logic [5:0] PALETTE_RESET = 6'h00;
    localparam logic [7:0] MODE_RD_MASK = 8'hEF;
    localparam logic [7:0] PLANE_EN_MASK = 8'h3F;
    localparam logic [7:0] LOW_NIBBLE_MASK = 8'h0F;

    // ****************************************************************
    // line graphics character range and mono underline attribute
    // ****************************************************************
    localparam logic [7:0] LINEGFX_FIRST = 8'hC0;
    localparam logic [7:0] LINEGFX_LAST = 8'hDF;
    localparam logic [2:0] MONO_UNDERLINE_ATTR = 3'h1;

    // ****************************************************************
    // index/data toggle
    // ****************************************************************
    typedef enum logic [0:0] {
        PORT_INDEX = 1'b0,
        PORT_DATA = 1'b1
    } vac_port_state_e;

endpackage : vac_pkg

//--- vac_pix_if.sv
// vac_pix_if: nibble stream into the 256-colour assembler and its byte result
`timescale 1ns/1ps
interface vac_pix_if;
    logic nib_valid;
    logic [3:0] nib;
    logic clear;
    logic byte_valid;
    logic [7:0] byte_val;

    modport src (output nib_valid, output nib, output clear, input byte_valid, input byte_val);
    modport asm (input nib_valid, input nib, input clear, output byte_valid, output byte_val);
endinterface : vac_pix_if

//--- vac_pixel_assembler.sv
// vac_pixel_assembler: pairs two 4-bit pixels into one 8-bit pixel
`timescale 1ns/1ps
module vac_pixel_assembler (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // nibble stream
    vac_pix_if.asm pix
);

    // ****************************************************************
    // pairing
    // ****************************************************************
    logic phase_reg;
    logic [3:0] first_reg;
    logic byte_valid_reg;
    logic [7:0] byte_reg;

    // first nibble is the upper half of the byte
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_reg <= 1'b0;
            first_reg <= 4'h0;
        end else if (pix.clear) begin
            phase_reg <= 1'b0;
        end else if (pix.nib_valid) begin
            phase_reg <= ~phase_reg;
            if (!phase_reg) begin
                first_reg <= pix.nib;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            byte_valid_reg <= 1'b0;
            byte_reg <= 8'h00;
        end else begin
            byte_valid_reg <= pix.nib_valid && phase_reg && !pix.clear;
            if (pix.nib_valid && phase_reg) begin
                byte_reg <= {first_reg, pix.nib};
            end
        end
    end

    assign pix.byte_valid = byte_valid_reg;
    assign pix.byte_val = byte_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_pair_completes: assert property (@(posedge ref_clk) disable iff (rst)
        (pix.nib_valid && phase_reg && !pix.clear) |=> (byte_valid_reg && byte_reg[7:4] == $past(first_reg)))
        else $error("second nibble did not complete a byte");
    chk_half_rate: assert property (@(posedge ref_clk) disable iff (rst)
        byte_valid_reg |=> !byte_valid_reg)
        else $error("assembled bytes faster than half the pixel rate");
    cov_byte_out: cover property (@(posedge ref_clk) disable iff (rst) byte_valid_reg);

endmodule : vac_pixel_assembler

//--- vac_attribute_controller.sv
// vac_attribute_controller: attribute unit register bank and pixel path
//
// How it works
// - palette source 0 (reset) blocks display palette use, host may access entries.
// - palette source 1 uses entries for display, host access refused.
// - data port at second address reads or writes the indexed register.
// - sixteen 6-bit entries: bits 5:3 secondary rgb, bits 2:0 primary rgb.
// - 256-colour bit clear: 4-bit pixel translated to 6 bits through palette.
// - 256-colour bit set: two 4-bit pixels form one 8-bit pixel, half rate.
// - pan force bit: line compare zeroes pan output until next vertical sync.
// - mode bit 3 chooses background intensity (0) or blink (1).
// - line graphics bit: ninth pixel copies eighth for codes C0-DF, else background.
// - mode bit 1 selects colour (0) or monochrome (1) text attributes.
// - mode bit 0 selects text (0) or graphics (1) attribute processing.
// - cleared plane enable forces that plane to zero before palette lookup.
// - 4-bit pan shift amount, reset zero, passed to the pan output the same in every mode unless forced to zero.
// - outside 256-colour mode, output bits 7:6 come from pad bits 3:2.
// - pad bits 1:0 supply colour output bits 5 and 4 when mode bit 7 is set, else palette entry bits 5:4.
`timescale 1ns/1ps
module vac_attribute_controller (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // host i/o cycles
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic toggle_clear,
    output logic [7:0] io_rdata,
    // display pixel stream
    input wire logic pix_valid,
    input wire logic display_active,
    input wire logic [3:0] plane_data,
    input wire logic glyph_bit,
    input wire logic ninth_col,
    input wire logic [7:0] char_code,
    input wire logic [7:0] attr_byte,
    input wire logic blink_phase,
    input wire logic underline_row,
    // raster events
    input wire logic line_compare,
    input wire logic vsync,
    // outputs
    output logic [7:0] colour_out,
    output logic colour_valid,
    output logic [3:0] pan_shift_out
);

    // ****************************************************************
    // registers
    // ****************************************************************
    vac_pkg::vac_port_state_e port_state_reg;
    logic [4:0] index_reg;
    logic pal_src_reg;
    logic [5:0] palette_reg [16];
    logic [7:0] mode_reg;
    logic [7:0] border_reg;
    logic [7:0] plane_en_reg;
    logic [7:0] pan_reg;
    logic [7:0] pad_reg;
    logic [7:0] io_rdata_reg;
    logic pan_zero_reg;
    logic last_glyph_reg;
    logic [7:0] colour_reg;
    logic colour_valid_reg;
    logic [3:0] pan_out_reg;

    // ****************************************************************
    // host decode
    // ****************************************************************
    logic idx_port_wr;
    logic data_wr;
    logic data_rd;
    logic idx_rd;
    logic sel_palette;
    logic palette_open;

    assign idx_port_wr = io_wr && (io_addr == vac_pkg::INDEX_PORT_ADDR);
    assign idx_rd = io_rd && (io_addr == vac_pkg::INDEX_PORT_ADDR);
    assign data_rd = io_rd && (io_addr == vac_pkg::DATA_PORT_ADDR);
    // data writes land through the index port on its data phase, or at the data port
    assign data_wr = (idx_port_wr && port_state_reg == vac_pkg::PORT_DATA)
        || (io_wr && io_addr == vac_pkg::DATA_PORT_ADDR);
    assign sel_palette = (index_reg <= vac_pkg::IDX_PALETTE_LAST);
    assign palette_open = sel_palette && !pal_src_reg;

    // toggle: clear from the host side wins over a concurrent write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_state_reg <= vac_pkg::PORT_INDEX;
        end else if (toggle_clear) begin
            port_state_reg <= vac_pkg::PORT_INDEX;
        end else if (idx_port_wr) begin
            case (port_state_reg)
                vac_pkg::PORT_INDEX: port_state_reg <= vac_pkg::PORT_DATA;
                vac_pkg::PORT_DATA: port_state_reg <= vac_pkg::PORT_INDEX;
                default: port_state_reg <= vac_pkg::PORT_INDEX;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            index_reg <= 5'h00;
            pal_src_reg <= 1'b0;
        end else if (idx_port_wr && port_state_reg == vac_pkg::PORT_INDEX && !toggle_clear) begin
            index_reg <= io_wdata[4:0];
            pal_src_reg <= io_wdata[vac_pkg::PAL_SRC_BIT];
        end
    end

    // palette writes only while the display is not using it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                palette_reg[i] <= vac_pkg::PALETTE_RESET;
            end
        end else if (data_wr && palette_open) begin
            palette_reg[index_reg[3:0]] <= io_wdata[5:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_reg <= vac_pkg::MODE_RESET;
            border_reg <= vac_pkg::BORDER_RESET;
            plane_en_reg <= vac_pkg::PLANE_EN_RESET;
            pan_reg <= vac_pkg::PAN_RESET;
            pad_reg <= vac_pkg::PAD_RESET;
        end else if (data_wr) begin
            case (index_reg)
                vac_pkg::IDX_MODE_CONTROL: mode_reg <= io_wdata & vac_pkg::MODE_RD_MASK;
                vac_pkg::IDX_BORDER_COLOUR: border_reg <= io_wdata;
                vac_pkg::IDX_PLANE_ENABLE: plane_en_reg <= io_wdata & vac_pkg::PLANE_EN_MASK;
                vac_pkg::IDX_HORIZ_PAN: pan_reg <= io_wdata & vac_pkg::LOW_NIBBLE_MASK;
                vac_pkg::IDX_PIXEL_PAD: pad_reg <= io_wdata & vac_pkg::LOW_NIBBLE_MASK;
                default: ;
            endcase
        end
    end

    // read data; refused palette reads and unmapped indices return zero
    logic [7:0] rd_sel;
    always_comb begin
        rd_sel = 8'h00;
        if (sel_palette) begin
            rd_sel = palette_open ? {2'b00, palette_reg[index_reg[3:0]]} : 8'h00;
        end else begin
            case (index_reg)
                vac_pkg::IDX_MODE_CONTROL: rd_sel = mode_reg;
                vac_pkg::IDX_BORDER_COLOUR: rd_sel = border_reg;
                vac_pkg::IDX_PLANE_ENABLE: rd_sel = plane_en_reg;
                vac_pkg::IDX_HORIZ_PAN: rd_sel = pan_reg;
                vac_pkg::IDX_PIXEL_PAD: rd_sel = pad_reg;
                default: rd_sel = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            io_rdata_reg <= 8'h00;
        end else if (idx_rd) begin
            io_rdata_reg <= {2'b00, pal_src_reg, index_reg};
        end else if (data_rd) begin
            io_rdata_reg <= rd_sel;
        end
    end

    // ****************************************************************
    // panning
    // ****************************************************************
    logic pan_zero_next;
    logic [3:0] pan_amt;

    assign pan_amt = pan_reg[3:0];
    // a line compare in the same cycle as vsync keeps the force
    always_comb begin
        pan_zero_next = pan_zero_reg;
        if (vsync) begin
            pan_zero_next = 1'b0;
        end
        if (line_compare && mode_reg[vac_pkg::MODE_PANFORCE_BIT]) begin
            pan_zero_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pan_zero_reg <= 1'b0;
            pan_out_reg <= 4'h0;
        end else begin
            pan_zero_reg <= pan_zero_next;
            pan_out_reg <= pan_zero_next ? 4'h0 : pan_amt;
        end
    end

    // ****************************************************************
    // attribute processing
    // ****************************************************************
    logic in_linegfx;
    logic glyph_eff;
    logic glyph_on;
    logic [3:0] bg_idx;
    logic [3:0] raw_idx;
    logic [3:0] pix_idx;
    logic [5:0] entry;

    assign in_linegfx = (char_code >= vac_pkg::LINEGFX_FIRST) && (char_code <= vac_pkg::LINEGFX_LAST);

    always_comb begin
        glyph_eff = glyph_bit;
        if (ninth_col) begin
            glyph_eff = (mode_reg[vac_pkg::MODE_LINEGFX_BIT] && in_linegfx) ? last_glyph_reg : 1'b0;
        end
        glyph_on = glyph_eff;
        // mono underline attribute lights the whole underline row
        if (mode_reg[vac_pkg::MODE_MONO_BIT] && underline_row
            && attr_byte[2:0] == vac_pkg::MONO_UNDERLINE_ATTR) begin
            glyph_on = 1'b1;
        end
        // blink trades background intensity for a blinking foreground
        if (mode_reg[vac_pkg::MODE_BLINK_BIT]) begin
            bg_idx = {1'b0, attr_byte[6:4]};
            if (attr_byte[7] && !blink_phase) begin
                glyph_on = 1'b0;
            end
        end else begin
            bg_idx = attr_byte[7:4];
        end
        raw_idx = mode_reg[vac_pkg::MODE_GRAPHICS_BIT] ? plane_data : (glyph_on ? attr_byte[3:0] : bg_idx);
    end

    assign pix_idx = raw_idx & plane_en_reg[3:0];
    assign entry = palette_reg[pix_idx];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            last_glyph_reg <= 1'b0;
        end else if (pix_valid && !ninth_col) begin
            last_glyph_reg <= glyph_bit;
        end
    end

    // ****************************************************************
    // 256-colour assembly
    // ****************************************************************
    logic mode_256;
    vac_pix_if pix_bus ();

    assign mode_256 = mode_reg[vac_pkg::MODE_256_BIT];
    assign pix_bus.nib_valid = pix_valid && display_active && mode_256;
    assign pix_bus.nib = pix_idx;
    assign pix_bus.clear = !mode_256 || !display_active || vsync;

    vac_pixel_assembler u_assembler (
        .ref_clk(ref_clk),
        .rst(rst),
        .pix(pix_bus)
    );

    // ****************************************************************
    // colour output
    // ****************************************************************
    logic [1:0] upper_pair;
    logic [1:0] colour_bits_upper_pair;

    assign upper_pair = pad_reg[3:2];
    assign colour_bits_upper_pair = mode_reg[vac_pkg::MODE_PAD54_BIT] ? pad_reg[1:0] : entry[5:4];

    // outside 256-colour mode, while the host owns the palette, the border colour stands in for pixels
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            colour_reg <= 8'h00;
            colour_valid_reg <= 1'b0;
        end else if (pix_valid && !display_active) begin
            colour_reg <= border_reg;
            colour_valid_reg <= 1'b1;
        end else if (mode_256) begin
            colour_reg <= pix_bus.byte_val;
            colour_valid_reg <= pix_bus.byte_valid;
        end else if (pix_valid) begin
            colour_valid_reg <= 1'b1;
            if (pal_src_reg) begin
                colour_reg <= {upper_pair, colour_bits_upper_pair, entry[3:0]};
            end else begin
                colour_reg <= border_reg;
            end
        end else begin
            colour_valid_reg <= 1'b0;
        end
    end

    assign io_rdata = io_rdata_reg;
    assign colour_out = colour_reg;
    assign colour_valid = colour_valid_reg;
    assign pan_shift_out = pan_out_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking chk_clk @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic normal_px;
    assign normal_px = pix_valid && display_active && !mode_256;

    chk_palette_blocked: assert property (
        (normal_px && !pal_src_reg) |=> (colour_valid && colour_out == $past(border_reg)))
        else $error("display used palette while host owns it");
    chk_host_refused: assert property (
        (data_rd && sel_palette && pal_src_reg && !idx_rd) |=> io_rdata == 8'h00)
        else $error("host read palette while display owns it");
    chk_mode_readback: assert property (
        (data_rd && !idx_rd && index_reg == vac_pkg::IDX_MODE_CONTROL) |=> io_rdata == $past(mode_reg))
        else $error("mode register read back wrong");
    chk_reserved_zero: assert property (
        (data_rd && !idx_rd && index_reg == vac_pkg::IDX_MODE_CONTROL) |=> !io_rdata[vac_pkg::MODE_RSVD_BIT])
        else $error("reserved mode bit read as one");
    chk_pan_forced: assert property (
        (line_compare && mode_reg[vac_pkg::MODE_PANFORCE_BIT])
        |=> pan_shift_out == 4'h0 ##1 (pan_shift_out == 4'h0 || $past(vsync)))
        else $error("pan not forced to zero after line compare");
    chk_pan_restored: assert property (
        (vsync && !line_compare) |=> pan_shift_out == $past(pan_amt))
        else $error("pan not restored after vsync");
    chk_plane_mask: assert property (
        (pix_idx & ~plane_en_reg[3:0]) == 4'h0)
        else $error("disabled plane reached palette index");
    chk_pad_top: assert property (
        (normal_px && pal_src_reg) |=> colour_out[7:6] == $past(upper_pair))
        else $error("colour bits 7:6 not taken from pad");
    chk_ninth_copy: assert property (
        (ninth_col && mode_reg[vac_pkg::MODE_LINEGFX_BIT] && in_linegfx) |-> glyph_eff == last_glyph_reg)
        else $error("ninth pixel did not copy eighth");
    chk_toggle_flip: assert property (
        (idx_port_wr && !toggle_clear) |=> port_state_reg != $past(port_state_reg))
        else $error("index port toggle did not alternate");

    cov_pan_force: cover property (line_compare && mode_reg[vac_pkg::MODE_PANFORCE_BIT] ##[1:50] vsync);
    cov_256_pixel: cover property (mode_256 && colour_valid);
    cov_palette_write: cover property (data_wr && palette_open);
    cov_border_px: cover property (pix_valid && !display_active);

endmodule : vac_attribute_controller

//--- vac_host_model.sv
// vac_host_model: host i/o master that drives the attribute unit ports
`timescale 1ns/1ps
module vac_host_model (
    // clock
    input wire logic ref_clk,
    // host bus
    output logic [15:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata,
    output logic toggle_clear,
    input wire logic [7:0] io_rdata
);
    initial begin
        io_addr = 16'h0000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
        toggle_clear = 1'b0;
    end
    // ****
    // bus cycles
    // ****
    // idle data shows the inverse so a stale value never looks driven
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        io_wr = 1'b0;
        io_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        io_addr = a;
        io_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        io_rd = 1'b0;
        @(posedge ref_clk);
        #1;
        d = io_rdata;
    endtask : rd
    // toggle cleared on demand; the bench calls it after reset and at the end of each getr read-back
    task automatic clr();
        @(posedge ref_clk);
        #1;
        toggle_clear = 1'b1;
        @(posedge ref_clk);
        #1;
        toggle_clear = 1'b0;
    endtask : clr
endmodule : vac_host_model

//--- tb.sv
// tb: self-checking bench for the attribute controller
`timescale 1ns/1ps
module tb;
    logic ref_clk, rst, io_wr, io_rd, toggle_clear, pix_valid, display_active, glyph_bit;
    logic ninth_col, blink_phase, underline_row, line_compare, vsync, colour_valid;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, char_code, attr_byte, colour_out, rd_val;
    logic [3:0] plane_data, pan_shift_out;
    logic [7:0] rv [5] = '{8'hEF, 8'hFF, 8'h3F, 8'h0F, 8'h0F};
    int fails = 0;
    int n_checks = 0;
    vac_host_model u_vac_host_model (.ref_clk(ref_clk), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .toggle_clear(toggle_clear), .io_rdata(io_rdata));
    vac_attribute_controller u_vac_attribute_controller (.ref_clk(ref_clk), .rst(rst),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .toggle_clear(toggle_clear), .io_rdata(io_rdata), .pix_valid(pix_valid),
        .display_active(display_active), .plane_data(plane_data), .glyph_bit(glyph_bit),
        .ninth_col(ninth_col), .char_code(char_code), .attr_byte(attr_byte),
        .blink_phase(blink_phase), .underline_row(underline_row), .line_compare(line_compare),
        .vsync(vsync), .colour_out(colour_out), .colour_valid(colour_valid),
        .pan_shift_out(pan_shift_out));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // ****
    // helpers
    // ****
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic setr(input logic [7:0] i, input logic [7:0] v);
        u_vac_host_model.wr(vac_pkg::INDEX_PORT_ADDR, i);
        u_vac_host_model.wr(vac_pkg::INDEX_PORT_ADDR, v);
    endtask : setr
    task automatic getr(input logic [7:0] i, input logic [7:0] exp);
        u_vac_host_model.wr(vac_pkg::INDEX_PORT_ADDR, i);
        u_vac_host_model.rd(vac_pkg::DATA_PORT_ADDR, rd_val);
        check(rd_val, exp);
        u_vac_host_model.clr();
    endtask : getr
    task automatic px(input logic act, input logic [3:0] pl, input logic [7:0] exp);
        @(posedge ref_clk);
        #1;
        pix_valid = 1'b1;
        display_active = act;
        plane_data = pl;
        @(posedge ref_clk);
        #1;
        pix_valid = 1'b0;
        check({7'h00, colour_valid}, 8'h01);
        check(colour_out, exp);
    endtask : px
    task automatic pulse_wait(input logic sel, input logic [7:0] exp);
        @(posedge ref_clk);
        #1;
        if (sel) line_compare = 1'b1;
        else vsync = 1'b1;
        @(posedge ref_clk);
        #1;
        line_compare = 1'b0;
        vsync = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check({4'h0, pan_shift_out}, exp);
    endtask : pulse_wait
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    initial begin
        #200000;
        fails++;
        wrap_up();
    end
    // ****
    // tests
    // ****
    initial begin
        {rst, pix_valid, display_active, glyph_bit, ninth_col, blink_phase} = 6'h3F;
        {pix_valid, display_active, glyph_bit, ninth_col, blink_phase} = 5'h00;
        {underline_row, line_compare, vsync, plane_data} = 7'h00;
        char_code = 8'h00;
        attr_byte = 8'h00;
        repeat (10) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        u_vac_host_model.clr();
        for (int k = 0; k < 5; k++) getr(8'h10 + k[7:0], 8'h00);
        for (int k = 0; k < 5; k++) setr(8'h10 + k[7:0], 8'hFF);
        for (int k = 0; k < 5; k++) getr(8'h10 + k[7:0], rv[k]);
        $display("test registers done");
        setr(8'h05, 8'h2A);
        setr(8'h01, 8'h07);
        getr(8'h05, 8'h2A);
        u_vac_host_model.rd(vac_pkg::INDEX_PORT_ADDR, rd_val);
        check(rd_val, 8'h05);
        setr(8'h10, 8'h01);
        px(1'b1, 4'h5, 8'hFF);
        px(1'b0, 4'h5, 8'hFF);
        setr(8'h25, 8'h11);
        getr(8'h25, 8'h00);
        $display("test palette done");
        setr(8'h32, 8'h0F);
        setr(8'h33, 8'h07);
        setr(8'h34, 8'h00);
        px(1'b1, 4'h5, 8'h2A);
        setr(8'h32, 8'h01);
        px(1'b1, 4'h5, 8'h07);
        setr(8'h32, 8'h0F);
        setr(8'h30, 8'h00);
        attr_byte = 8'h15;
        glyph_bit = 1'b1;
        px(1'b1, 4'h0, 8'h2A);
        glyph_bit = 1'b0;
        px(1'b1, 4'h0, 8'h07);
        setr(8'h30, 8'h08);
        {attr_byte, glyph_bit, blink_phase} = {8'h95, 2'b10};
        px(1'b1, 4'h0, 8'h07);
        blink_phase = 1'b1;
        px(1'b1, 4'h0, 8'h2A);
        setr(8'h30, 8'h00);
        glyph_bit = 1'b0;
        px(1'b1, 4'h0, 8'h00);
        setr(8'h30, 8'h02);
        {attr_byte, underline_row} = {8'h51, 1'b1};
        px(1'b1, 4'h0, 8'h07);
        underline_row = 1'b0;
        px(1'b1, 4'h0, 8'h2A);
        setr(8'h30, 8'h04);
        {attr_byte, glyph_bit} = {8'h15, 1'b1};
        px(1'b1, 4'h0, 8'h2A);
        {ninth_col, glyph_bit, char_code} = {2'b10, 8'hC4};
        px(1'b1, 4'h0, 8'h2A);
        char_code = 8'h41;
        px(1'b1, 4'h0, 8'h07);
        ninth_col = 1'b0;
        setr(8'h30, 8'h81);
        setr(8'h34, 8'h0F);
        px(1'b1, 4'h5, 8'hFA);
        setr(8'h30, 8'h01);
        px(1'b1, 4'h5, 8'hEA);
        $display("test pixels done");
        check({4'h0, pan_shift_out}, 8'h07);
        setr(8'h30, 8'h21);
        pulse_wait(1'b1, 8'h00);
        pulse_wait(1'b0, 8'h07);
        setr(8'h30, 8'h41);
        @(posedge ref_clk);
        #1;
        {pix_valid, display_active, plane_data} = 6'h33;
        @(posedge ref_clk);
        #1;
        plane_data = 4'hC;
        @(posedge ref_clk);
        #1;
        pix_valid = 1'b0;
        @(posedge ref_clk);
        #1;
        check({7'h00, colour_valid}, 8'h01);
        check(colour_out, 8'h3C);
        $display("test pan and 256 done");
        wrap_up();
    end
endmodule : tb
